// file: core/disk_link.v
// Functional notes
// - free 4.1 MHz clock shifts command bits
// - status command fetches status; seek moves heads
// - command word sent bit zero first
// - two unit select lines from control
// - record gate plus serial record data
// - record data is MFM encoded
// - read status word to learn fault
// - read data valid when selected, ready
// - decode MFM read data per cell
// - one sector is 2240 cells
// - seek sends supplied word to drive
// - status word stored in buffer
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "disk_link_consts.vh"
module disk_link (
	input wire core_clk,
	input wire nrst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg drive_timing_clock,
	output reg drive_command_line,
	output reg [1:0] unit_select_lines,
	output reg line_power_low_n,
	output reg record_gate,
	output reg record_data_line,
	input wire mains_low_n,
	input wire drive_ready_line,
	input wire drive_fault_line,
	input wire drive_status_line,
	input wire drive_status_strobe,
	input wire sector_mark_pulse,
	input wire playback_data_line
);
	parameter STAT_TMO = `STAT_TMO_CYC;

	localparam S_IDLE = 3'h0;
	localparam S_WRDY = 3'h1;
	localparam S_SEND = 3'h2;
	localparam S_STAT = 3'h3;
	localparam S_WSEC = 3'h4;
	localparam S_READ = 3'h5;
	localparam S_WRITE = 3'h6;

	function [2:0] dec;
		input [5:0] a;
		begin
			case (a)
				`REG_CTRL: dec = 3'h1;
				`REG_CMD: dec = 3'h2;
				`REG_STAT: dec = 3'h3;
				`REG_DSTAT: dec = 3'h4;
				`REG_BPTR: dec = 3'h5;
				`REG_BDATA: dec = 3'h6;
				default: dec = 3'h0;
			endcase
		end
	endfunction

	// three-flop pin filter
	reg [`NPINS-1:0] s1_r, s2_r, s3_r, filt_r, filt_d_r;
	wire [`NPINS-1:0] pins;
	wire [`NPINS-1:0] filt_init = `FILT_RST;
	assign pins = {mains_low_n, playback_data_line, sector_mark_pulse, drive_status_strobe,
		drive_status_line, drive_fault_line, drive_ready_line};
	genvar gi;
	generate
		for (gi = 0; gi < `NPINS; gi = gi + 1) begin : g_sync
			always @(posedge core_clk) begin
				if (!nrst) begin
					s1_r[gi] <= filt_init[gi];
					s2_r[gi] <= filt_init[gi];
					s3_r[gi] <= filt_init[gi];
					filt_r[gi] <= filt_init[gi];
					filt_d_r[gi] <= filt_init[gi];
				end else begin
					s1_r[gi] <= pins[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi]) begin
						filt_r[gi] <= s3_r[gi];
					end
					filt_d_r[gi] <= filt_r[gi];
				end
			end
		end
	endgenerate
	wire rdy = filt_r[`PIN_READY];
	wire flt = filt_r[`PIN_FAULT];
	wire strobe_rise = filt_r[`PIN_STROBE] & ~filt_d_r[`PIN_STROBE];
	wire sector_rise = filt_r[`PIN_SECTOR] & ~filt_d_r[`PIN_SECTOR];

	// bit-cell timebase
	reg [4:0] div_r;
	wire tick_rise = (div_r == 5'h00);
	wire tick_fall = (div_r == `HALF_CYC);

	reg [2:0] state_r, op_r;
	reg [15:0] cmd_r, sh_r, dstat_r;
	reg [4:0] bit_r;
	reg [11:0] cell_r;
	reg [7:0] bptr_r, eptr_r;
	reg [15:0] tmo_r;
	reg prev_r, seen_r, started_r;
	reg sdone_r, stmo_r, rderr_r, rdone_r, wdone_r;
	reg eng_we_r;
	reg [15:0] eng_wd_r;
	wire [15:0] mem_rd;

	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire [2:0] sel_reg = dec(wb_adr_i);
	wire wr = req & wb_we_i;
	wire idle = (state_r == S_IDLE);
	wire start = wr & (sel_reg == 3'h1) & wb_sel_i[0] & idle &
		(wb_dat_i[`CTRL_OP_LSB+2:`CTRL_OP_LSB] != `OP_NONE);
	wire sw_we = wr & (sel_reg == 3'h6) & idle;
	wire buf_acc = req & (sel_reg == 3'h6) & idle;
	// engine write may land in the first idle cycle, so it takes priority
	wire [7:0] mem_addr = (idle & ~eng_we_r) ? bptr_r : eptr_r;
	wire mem_we = eng_we_r | (sw_we & ~eng_we_r);
	wire [15:0] mem_wd = eng_we_r ? eng_wd_r : wb_dat_i[15:0];
	wire [9:0] stat_word = {wdone_r, rdone_r, rderr_r, stmo_r, sdone_r,
		~filt_r[`PIN_MAINS], filt_r[`PIN_SECTOR], flt, rdy, ~idle};
	wire clr = wr & (sel_reg == 3'h3);

	sector_buffer u_buf (
		.core_clk(core_clk),
		.wr_en(mem_we),
		.addr(mem_addr),
		.wr_data(mem_wd),
		.rd_data(mem_rd)
	);

	// free-running drive clock
	always @(posedge core_clk) begin
		if (!nrst) begin
			div_r <= 5'h00;
			drive_timing_clock <= 1'b0;
		end else begin
			if (div_r == `BIT_CYC - 1) begin
				div_r <= 5'h00;
			end else begin
				div_r <= div_r + 5'h01;
			end
			if (tick_rise) begin
				drive_timing_clock <= 1'b1;
			end else if (tick_fall) begin
				drive_timing_clock <= 1'b0;
			end
		end
	end

	// bus slave
	always @(posedge core_clk) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			cmd_r <= `CMD_RST;
			unit_select_lines <= 2'h0;
			bptr_r <= 8'h00;
			line_power_low_n <= 1'b1;
		end else begin
			line_power_low_n <= filt_r[`PIN_MAINS];
			wb_ack_o <= req;
			if (wr & (sel_reg == 3'h1) & wb_sel_i[0] & idle) begin
				unit_select_lines <= wb_dat_i[`CTRL_UNIT_LSB+1:`CTRL_UNIT_LSB];
			end
			if (wr & (sel_reg == 3'h2)) begin
				if (wb_sel_i[0]) begin
					cmd_r[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					cmd_r[15:8] <= wb_dat_i[15:8];
				end
			end
			if (wr & (sel_reg == 3'h5) & wb_sel_i[0] & idle) begin
				bptr_r <= wb_dat_i[7:0];
			end else if (buf_acc) begin
				bptr_r <= bptr_r + 8'h01;
			end
			if (req & ~wb_we_i) begin
				case (sel_reg)
					3'h1: wb_dat_o <= {25'h0, op_r, 2'h0, unit_select_lines};
					3'h2: wb_dat_o <= {16'h0, cmd_r};
					3'h3: wb_dat_o <= {22'h0, stat_word};
					3'h4: wb_dat_o <= {16'h0, dstat_r};
					3'h5: wb_dat_o <= {24'h0, bptr_r};
					3'h6: wb_dat_o <= {16'h0, mem_rd};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// sequencer
	always @(posedge core_clk) begin
		if (!nrst) begin
			state_r <= S_IDLE;
			op_r <= `OP_NONE;
			sh_r <= 16'h0000;
			dstat_r <= 16'h0000;
			bit_r <= 5'h00;
			cell_r <= 12'h000;
			eptr_r <= 8'h00;
			tmo_r <= 16'h0000;
			prev_r <= 1'b0;
			seen_r <= 1'b0;
			started_r <= 1'b0;
			eng_we_r <= 1'b0;
			eng_wd_r <= 16'h0000;
			drive_command_line <= 1'b0;
			record_gate <= 1'b0;
			record_data_line <= 1'b0;
			sdone_r <= 1'b0;
			stmo_r <= 1'b0;
			rderr_r <= 1'b0;
			rdone_r <= 1'b0;
			wdone_r <= 1'b0;
		end else begin
			eng_we_r <= 1'b0;
			if (clr & wb_sel_i[0]) begin
				sdone_r <= 1'b0;
				stmo_r <= 1'b0;
				rderr_r <= 1'b0;
			end
			if (clr & wb_sel_i[1]) begin
				rdone_r <= 1'b0;
				wdone_r <= 1'b0;
			end
			case (state_r)
				S_IDLE: begin
					if (start) begin
						op_r <= wb_dat_i[`CTRL_OP_LSB+2:`CTRL_OP_LSB];
						state_r <= S_WRDY;
					end else begin
						op_r <= `OP_NONE;
					end
				end
				S_WRDY: begin
					eptr_r <= 8'h00;
					cell_r <= 12'h000;
					bit_r <= 5'h00;
					started_r <= 1'b0;
					// status may be fetched from a faulted drive
					if (rdy | ((op_r == `OP_GSTAT) & flt)) begin
						if ((op_r == `OP_SEEK) | (op_r == `OP_GSTAT)) begin
							sh_r <= cmd_r;
							state_r <= S_SEND;
						end else if ((op_r == `OP_READ) | (op_r == `OP_WRITE)) begin
							state_r <= S_WSEC;
						end else begin
							state_r <= S_IDLE;
						end
					end
				end
				S_SEND: begin
					if (tick_fall) begin
						if (bit_r == `CMD_BITS) begin
							drive_command_line <= 1'b0;
							bit_r <= 5'h00;
							tmo_r <= 16'h0000;
							state_r <= (op_r == `OP_GSTAT) ? S_STAT : S_IDLE;
						end else begin
							drive_command_line <= sh_r[0];
							sh_r <= {1'b0, sh_r[15:1]};
							bit_r <= bit_r + 5'h01;
						end
					end
				end
				S_STAT: begin
					tmo_r <= tmo_r + 16'h0001;
					if (strobe_rise) begin
						sh_r <= {filt_r[`PIN_STAT], sh_r[15:1]};
						bit_r <= bit_r + 5'h01;
						if (bit_r == `CMD_BITS - 1) begin
							// later strobes are ignored
							dstat_r <= {filt_r[`PIN_STAT], sh_r[15:1]};
							eng_wd_r <= {filt_r[`PIN_STAT], sh_r[15:1]};
							eng_we_r <= 1'b1;
							sdone_r <= 1'b1;
							state_r <= S_IDLE;
						end
					end else if (tmo_r == STAT_TMO) begin
						stmo_r <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				S_WSEC: begin
					if (sector_rise & rdy) begin
						sh_r <= mem_rd;
						eptr_r <= 8'h01;
						prev_r <= 1'b0;
						started_r <= 1'b0;
						if (op_r == `OP_WRITE) begin
							record_gate <= 1'b1;
							state_r <= S_WRITE;
						end else begin
							state_r <= S_READ;
						end
					end
				end
				S_WRITE: begin
					if (tick_rise) begin
						started_r <= 1'b1;
						record_data_line <= ~prev_r & ~sh_r[0];
					end else if (tick_fall & started_r) begin
						record_data_line <= sh_r[0];
						prev_r <= sh_r[0];
						if (cell_r[3:0] == 4'hf) begin
							sh_r <= mem_rd;
							eptr_r <= eptr_r + 8'h01;
						end else begin
							sh_r <= {1'b0, sh_r[15:1]};
						end
						if (cell_r == `SECTOR_CELLS - 1) begin
							record_gate <= 1'b0;
							wdone_r <= 1'b1;
							state_r <= S_IDLE;
						end
						cell_r <= cell_r + 12'h001;
					end
					if (tick_fall & started_r & (cell_r == `SECTOR_CELLS - 1)) begin
						record_data_line <= 1'b0;
					end
				end
				S_READ: begin
					if (filt_r[`PIN_PLAY] & ~tick_rise & ~tick_fall) begin
						seen_r <= 1'b1;
					end
					if (tick_fall) begin
						seen_r <= 1'b0;
						started_r <= 1'b1;
					end else if (tick_rise & started_r) begin
						seen_r <= 1'b0;
						// data half pulse means a one
						sh_r <= {seen_r, sh_r[15:1]};
						if (cell_r[3:0] == 4'hf) begin
							eng_wd_r <= {seen_r, sh_r[15:1]};
							eng_we_r <= 1'b1;
						end
						if (cell_r[3:0] == 4'h0 && cell_r != 12'h000) begin
							eptr_r <= eptr_r + 8'h01;
						end
						if (cell_r == `SECTOR_CELLS - 1) begin
							rdone_r <= 1'b1;
							state_r <= S_IDLE;
						end
						cell_r <= cell_r + 12'h001;
					end
					if (~rdy) begin
						rderr_r <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				default: state_r <= S_IDLE;
			endcase
			if (state_r == S_WSEC && sector_rise && rdy && op_r == `OP_READ) begin
				eptr_r <= 8'h00;
			end
		end
	end
endmodule // disk_link

// file: core/disk_link_consts.vh
`ifndef DISK_LINK_CONSTS_VH
`define DISK_LINK_CONSTS_VH
// register byte offsets
`define REG_CTRL 6'h00
`define REG_CMD 6'h04
`define REG_STAT 6'h08
`define REG_DSTAT 6'h0c
`define REG_BPTR 6'h10
`define REG_BDATA 6'h14
// control fields
`define CTRL_UNIT_LSB 0
`define CTRL_OP_LSB 4
`define OP_NONE 3'h0
`define OP_SEEK 3'h1
`define OP_GSTAT 3'h2
`define OP_READ 3'h3
`define OP_WRITE 3'h4
// status bit positions
`define ST_BUSY 0
`define ST_READY 1
`define ST_FAULT 2
`define ST_SECTOR 3
`define ST_PWRLOW 4
`define ST_SDONE 5
`define ST_STMO 6
`define ST_RDERR 7
`define ST_RDONE 8
`define ST_WDONE 9
// reset values
`define CTRL_RST 32'h0000_0000
`define CMD_RST 16'h0000
`define FILT_RST 7'h40
// pin filter indices
`define PIN_READY 0
`define PIN_FAULT 1
`define PIN_STAT 2
`define PIN_STROBE 3
`define PIN_SECTOR 4
`define PIN_PLAY 5
`define PIN_MAINS 6
`define NPINS 7
// timing
`define CORE_PERIOD_PS 10000
`define BIT_TIME_PS 243900
`define BIT_CYC (`BIT_TIME_PS / `CORE_PERIOD_PS)
`define HALF_CYC (`BIT_CYC / 2)
`define CMD_BITS 16
`define SECTOR_CELLS 2240
`define STAT_TMO_US 40
`define STAT_TMO_CYC (`STAT_TMO_US * 1000000 / `CORE_PERIOD_PS)
`endif

// file: core/sector_buffer.v
`timescale 1ns/1ns
module sector_buffer (
	input wire core_clk,
	input wire wr_en,
	input wire [7:0] addr,
	input wire [15:0] wr_data,
	output reg [15:0] rd_data
);
	reg [15:0] mem [0:255];

	// read data registered, write-first not guaranteed
	always @(posedge core_clk) begin
		if (wr_en) begin
			mem[addr] <= wr_data;
		end
		rd_data <= mem[addr];
	end
endmodule // sector_buffer

// file: testbench/disk_link_assertions.sv
`timescale 1ns/1ns
`include "disk_link_consts.vh"
module disk_link_checker #(
	parameter int STAT_TMO = 4000
) (
	input wire core_clk,
	input wire nrst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire drive_timing_clock,
	input wire drive_command_line,
	input wire [1:0] unit_select_lines,
	input wire line_power_low_n,
	input wire mains_low_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not one cycle after request");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > `REG_BDATA
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	tclk_high_a: assert property ($rose(drive_timing_clock) |-> ##12 $fell(drive_timing_clock))
		else $error("timing clock high phase wrong");
	tclk_low_a: assert property ($fell(drive_timing_clock) |-> ##12 $rose(drive_timing_clock))
		else $error("timing clock low phase wrong");
	cmd_edge_a: assert property ($changed(drive_command_line) |-> !drive_timing_clock)
		else $error("command bit moved while clock high");
	power_down_a: assert property ($fell(mains_low_n) |-> ##[1:8] !line_power_low_n)
		else $error("power low not passed on");
	power_up_a: assert property ($rose(mains_low_n) |-> ##[1:8] line_power_low_n)
		else $error("power return not passed on");
	unit_write_a: assert property ($changed(unit_select_lines) |->
		$past(wb_cyc_i && wb_we_i && wb_adr_i == `REG_CTRL)
		|| (wb_cyc_i && wb_we_i && wb_adr_i == `REG_CTRL)) else $error("unit moved alone");
endmodule // disk_link_checker
bind disk_link disk_link_checker #(.STAT_TMO(STAT_TMO)) disk_link_checker_i (.*);

// file: testbench/drive_model.sv
`timescale 1ns/1ns
module drive_model #(
	parameter logic [1:0] UNIT = 2'h2,
	parameter logic [15:0] STATUS = 16'hc3a5,
	parameter logic [15:0] GSTAT = 16'h000b
) (
	input wire drive_timing_clock,
	input wire drive_command_line,
	input wire [1:0] unit_select_lines,
	input wire record_gate,
	input wire line_power_low_n,
	output logic drive_ready_line,
	output logic drive_status_line,
	output logic drive_status_strobe,
	output logic [15:0] got_word
);
	logic [4:0] rx = 5'h0;
	logic [15:0] sh = 16'h0;
	logic [5:0] tx = 6'h0;
	logic busy = 1'b0;
	logic sending = 1'b0;
	logic on = 1'b0;
	int settle = 0;
	wire sel = unit_select_lines == UNIT;
	wire [15:0] word = {drive_command_line, sh[15:1]};
	initial got_word = 16'h0;
	initial drive_status_line = 1'b0;
	always @(posedge drive_timing_clock) begin
		if (rx == 5'h0 && !busy && sel && drive_command_line) begin
			rx <= 5'h1;
			sh <= word;
			busy <= 1'b1;
			sending <= 1'b0;
		end else if (rx != 5'h0) begin
			sh <= word;
			rx <= (rx == 5'hf) ? 5'h0 : rx + 5'h1;
			if (rx == 5'hf) begin
				got_word <= word;
				settle <= 8;
				sending <= word == GSTAT;
				tx <= 6'h0;
			end
		end else if (settle != 0) begin
			settle <= settle - 1;
			if (settle == 1)
				busy <= 1'b0;
		end
	end
	// bits change at falling edge, strobe rises mid-bit; stray clocks carry inverted bits
	always @(negedge drive_timing_clock) begin
		on <= sending;
		if (sending) begin
			drive_status_line <= (tx < 6'h10) ? STATUS[tx[3:0]] : ~STATUS[tx[3:0]];
			tx <= tx + 6'h1;
		end else
			drive_status_line <= ~drive_status_line;
	end
	assign drive_status_strobe = on & drive_timing_clock & sel;
	assign drive_ready_line = sel & !busy & !record_gate & line_power_low_n;
endmodule // drive_model

// file: testbench/disk_link_tb.sv
`timescale 1ns/1ns
`include "disk_link_consts.vh"
module disk_link_tb;
	logic core_clk = 0, nrst = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, mains_low_n = 1;
	logic [5:0] wb_adr_i = 6'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, q;
	logic drive_fault_line = 0, sector_mark_pulse = 0, playback_data_line = 0;
	wire [31:0] wb_dat_o;
	wire [1:0] unit_select_lines;
	wire [15:0] got_word;
	wire wb_ack_o, drive_timing_clock, drive_command_line, line_power_low_n, record_gate;
	wire record_data_line, drive_ready_line, drive_status_line, drive_status_strobe;
	int fail_count = 0, checks_done = 0;
	logic [38:0] rows [0:6] = '{{1'b0, `REG_CTRL, 32'h0}, {1'b1, `REG_CMD, 32'h1234},
		{1'b0, `REG_CMD, 32'h1234}, {1'b1, `REG_BPTR, 32'h05}, {1'b0, `REG_BPTR, 32'h05},
		{1'b1, 6'h3c, 32'hffff}, {1'b0, 6'h3c, 32'h0}};
	disk_link #(.STAT_TMO(2000)) disk_link_i (.*);
	drive_model drive_model_i (.*);
	always #5 core_clk = ~core_clk;
	task test_done;
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wb(input logic we, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'h3;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		if (n >= 50)
			chk("ack", 0, 1);
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge core_clk);
	endtask
	task wait_idle;
		int n;
		n = 0;
		do begin
			wb(0, `REG_STAT, 0);
			n++;
		end while (q[`ST_BUSY] !== 1'b0 && n < 1000);
		chk("busy", q[`ST_BUSY], 0);
	endtask
	initial begin
		#400000;
		fail_count++;
		test_done();
	end
	initial begin
		repeat (8) @(posedge core_clk);
		nrst <= 1;
		@(posedge core_clk);
		chk("power_out", line_power_low_n, 1);
		chk("gate", record_gate, 0);
		repeat (8) @(posedge core_clk);
		for (int i = 0; i < 7; i++) begin
			wb(rows[i][38], rows[i][37:32], rows[i][31:0]);
			if (!rows[i][38])
				chk("reg", q, rows[i][31:0]);
		end
		// seek then get status back to back: second must wait for ready
		wb(1, `REG_CMD, 32'h5a35);
		wb(1, `REG_CTRL, 32'h12);
		wait_idle();
		chk("cmd_word", got_word, 16'h5a35);
		chk("unit", unit_select_lines, 2'h2);
		wb(1, `REG_CMD, 32'h000b);
		wb(1, `REG_CTRL, 32'h22);
		wait_idle();
		chk("sdone", q[`ST_SDONE], 1);
		wb(0, `REG_DSTAT, 0);
		chk("dstat", q[15:0], 16'hc3a5);
		wb(1, `REG_BPTR, 0);
		wb(0, `REG_BDATA, 0);
		chk("buf0", q[15:0], 16'hc3a5);
		sector_mark_pulse <= 1;
		repeat (10) @(posedge core_clk);
		wb(0, `REG_STAT, 0);
		chk("sector", q[`ST_SECTOR], 1);
		sector_mark_pulse <= 0;
		drive_fault_line <= 1;
		repeat (10) @(posedge core_clk);
		wb(0, `REG_STAT, 0);
		chk("fault", q[`ST_FAULT], 1);
		drive_fault_line <= 0;
		repeat (10) @(posedge core_clk);
		wb(0, `REG_STAT, 0);
		chk("fault_gone", q[`ST_FAULT], 0);
		mains_low_n <= 0;
		repeat (10) @(posedge core_clk);
		chk("power_low", line_power_low_n, 0);
		mains_low_n <= 1;
		repeat (10) @(posedge core_clk);
		chk("power_back", line_power_low_n, 1);
		test_done();
	end
endmodule // disk_link_tb
